// *** include/bcc_pkg.sv ***
// Package of constants and types for the branch cache control block.
package bcc_pkg;
  // ****************************************
  // Control register
  // ****************************************
  localparam logic [7:0] CTRL_ADDR = 8'ha1;
  localparam logic [7:0] CTRL_RST  = 8'he6;
  localparam int         WREN_BIT  = 7;
  localparam int         RDEN_BIT  = 6;
  localparam int         PFEN_BIT  = 5;
  localparam int         FLSH_BIT  = 4;
  localparam int         RETI_BIT  = 3;
  localparam int         ISR_BIT   = 2;
  localparam int         MOVC_BIT  = 1;
  localparam int         BLKW_BIT  = 0;
  // ****************************************
  // Slots and lock pointer
  // ****************************************
  localparam int         SLOT_W       = 6;
  localparam logic [5:0] LOCK_PTR_RST = 6'h3f;
  localparam logic [5:0] SLOT_ZERO    = 6'h00;
  localparam logic [5:0] SLOT_ONE     = 6'h01;
  typedef enum logic [1:0] {
    BCC_UP   = 2'b01,
    BCC_DOWN = 2'b10
  } bcc_dir_t;
endpackage

// *** include/bcc_vld_if.sv ***
// Interface between the cache control and the slot valid-bit store.
`timescale 1ns/100ps
interface bcc_vld_if #(parameter int SLOT_W = 6);
  logic              clear_all;
  logic              set_en;
  logic [SLOT_W-1:0] set_slot;
  logic              clr_en;
  logic [SLOT_W-1:0] clr_slot;
  logic              rd_en;
  logic [SLOT_W-1:0] rd_slot;
  logic              rd_valid;
  modport ctrl (output clear_all, set_en, set_slot, clr_en, clr_slot, rd_en, rd_slot,
                input  rd_valid);
  modport mem  (input  clear_all, set_en, set_slot, clr_en, clr_slot, rd_en, rd_slot,
                output rd_valid);
endinterface

// *** hdl/bcc_valid_mem.sv ***
// Valid-bit store for the cache slots with a registered read port.
`timescale 1ns/100ps
module bcc_valid_mem #(
  parameter int SLOT_W = 6
) (
  input wire logic CLK,
  input wire logic NRST,
  bcc_vld_if.mem   vif
);
  localparam int SLOTS = 1 << SLOT_W;

  // The valid vector is a flat register, so very wide slot indices are refused.
  if (SLOT_W < 1 || SLOT_W > 8) begin : g_bad_slot_w
    $error("Slot index width must lie between 1 and 8.");
  end

  logic [SLOTS-1:0] valid;
  logic [SLOTS-1:0] next_valid;
  logic             next_rd_valid;
  logic             rd_valid_q;

  // ****************************************
  // Per-slot update
  // ****************************************
  // A fill write and an invalidate of the same slot may coincide; set wins over clear, clear_all over both.
  for (genvar i = 0; i < SLOTS; i++) begin : g_slot
    always_comb begin
      if (vif.clear_all) begin
        next_valid[i] = 1'b0;
      end else if (vif.set_en && vif.set_slot == SLOT_W'(i)) begin
        next_valid[i] = 1'b1;
      end else if (vif.clr_en && vif.clr_slot == SLOT_W'(i)) begin
        next_valid[i] = 1'b0;
      end else begin
        next_valid[i] = valid[i];
      end
    end
  end

  always_comb begin
    next_rd_valid = vif.rd_en ? valid[vif.rd_slot] : 1'b0;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      valid      <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      valid      <= next_valid;
      rd_valid_q <= next_rd_valid;
    end
  end

  assign vif.rd_valid = rd_valid_q;
endmodule

// *** hdl/bcc_top.sv ***
// Branch target cache control: control register, fill gating, lock pointer, hit gating.
`timescale 1ns/100ps
module bcc_top (
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  input  wire logic       LOOKUP_REQ,
  input  wire logic [5:0] LOOKUP_SLOT,
  output logic            HIT_USE,
  input  wire logic       FILL_REQ,
  input  wire logic       FILL_IS_RETI,
  input  wire logic       FILL_IS_ISR,
  input  wire logic       FILL_IS_MOVC,
  input  wire logic       PUSH_REQ,
  input  wire logic       POP_REQ,
  input  wire logic       FLASH_INV,
  input  wire logic [5:0] FLASH_INV_SLOT,
  output logic            SLOT_WE,
  output logic      [5:0] SLOT_WSEL,
  output logic      [5:0] LOCK_POINTER,
  output logic            PREFETCH_EN,
  output logic            FLASH_BLOCK_WRITE
);
  localparam int SW = bcc_pkg::SLOT_W;

  bcc_vld_if #(.SLOT_W(SW)) vif ();

  bcc_valid_mem #(.SLOT_W(SW)) u_mem (
    .CLK  (CLK),
    .NRST (NRST),
    .vif  (vif)
  );

  // ****************************************
  // Control register
  // ****************************************
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic       flush;
  logic       next_flush;
  logic [7:0] next_rdata;
  logic       ctrl_wr;

  assign ctrl_wr = SFR_WR && SFR_ADDR == bcc_pkg::CTRL_ADDR;

  always_comb begin
    next_ctrl  = ctrl;
    next_flush = 1'b0;
    if (ctrl_wr) begin
      next_ctrl                    = SFR_WDATA;
      next_ctrl[bcc_pkg::FLSH_BIT] = 1'b0;
      next_flush                   = SFR_WDATA[bcc_pkg::FLSH_BIT];
    end
    next_rdata = 8'h00;
    if (SFR_RD && SFR_ADDR == bcc_pkg::CTRL_ADDR) begin
      next_rdata = ctrl;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl      <= bcc_pkg::CTRL_RST;
      flush     <= 1'b0;
      SFR_RDATA <= 8'h00;
    end else begin
      ctrl      <= next_ctrl;
      flush     <= next_flush;
      SFR_RDATA <= next_rdata;
    end
  end

  assign PREFETCH_EN       = ctrl[bcc_pkg::PFEN_BIT];
  assign FLASH_BLOCK_WRITE = ctrl[bcc_pkg::BLKW_BIT];

  // ****************************************
  // Fill eligibility and slot writes
  // ****************************************
  // Read enable takes no part here, so fills go on while hits are suppressed.
  logic fill_ok;
  assign fill_ok = FILL_REQ && ctrl[bcc_pkg::WREN_BIT]
                && (!FILL_IS_RETI || ctrl[bcc_pkg::RETI_BIT])
                && (!FILL_IS_ISR  || ctrl[bcc_pkg::ISR_BIT])
                && (!FILL_IS_MOVC || ctrl[bcc_pkg::MOVC_BIT]);

  logic [5:0]        lock_ptr;
  logic [5:0]        next_lock_ptr;
  logic [5:0]        victim;
  logic [5:0]        next_victim;
  bcc_pkg::bcc_dir_t dir;
  bcc_pkg::bcc_dir_t next_dir;
  logic              next_we;
  logic [5:0]        next_wsel;
  logic              do_push;
  logic              do_fill;
  logic [5:0]        vict_use;

  // Flush and flash invalidation own the cycle; a push beats a fill.
  assign do_push  = PUSH_REQ && !flush && !FLASH_INV;
  assign do_fill  = fill_ok && !flush && !FLASH_INV && !PUSH_REQ;
  // The pointer may have moved below the rebound position after a push.
  assign vict_use = (victim > lock_ptr) ? lock_ptr : victim;

  always_comb begin
    next_lock_ptr = lock_ptr;
    next_victim   = vict_use;
    next_dir      = dir;
    next_we       = 1'b0;
    next_wsel     = SLOT_WSEL;
    if (do_push) begin
      next_we   = 1'b1;
      next_wsel = lock_ptr;
      if (lock_ptr != bcc_pkg::SLOT_ZERO) begin
        next_lock_ptr = lock_ptr - bcc_pkg::SLOT_ONE;
      end
    end else if (do_fill) begin
      next_we   = 1'b1;
      next_wsel = vict_use;
      case (dir)
        bcc_pkg::BCC_UP: begin
          if (vict_use >= lock_ptr) begin
            next_dir    = bcc_pkg::BCC_DOWN;
            next_victim = (vict_use == bcc_pkg::SLOT_ZERO) ? vict_use
                          : vict_use - bcc_pkg::SLOT_ONE;
          end else begin
            next_victim = vict_use + bcc_pkg::SLOT_ONE;
          end
        end
        bcc_pkg::BCC_DOWN: begin
          if (vict_use == bcc_pkg::SLOT_ZERO) begin
            next_dir    = bcc_pkg::BCC_UP;
            next_victim = (lock_ptr == bcc_pkg::SLOT_ZERO) ? vict_use
                          : bcc_pkg::SLOT_ONE;
          end else begin
            next_victim = vict_use - bcc_pkg::SLOT_ONE;
          end
        end
        default: begin
          next_dir = bcc_pkg::BCC_UP;
        end
      endcase
    end
    // Pop only moves the pointer; slot contents stay valid.
    if (POP_REQ && !do_push && lock_ptr != bcc_pkg::LOCK_PTR_RST) begin
      next_lock_ptr = lock_ptr + bcc_pkg::SLOT_ONE;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lock_ptr  <= bcc_pkg::LOCK_PTR_RST;
      victim    <= bcc_pkg::SLOT_ZERO;
      dir       <= bcc_pkg::BCC_UP;
      SLOT_WE   <= 1'b0;
      SLOT_WSEL <= bcc_pkg::SLOT_ZERO;
    end else begin
      lock_ptr  <= next_lock_ptr;
      victim    <= next_victim;
      dir       <= next_dir;
      SLOT_WE   <= next_we;
      SLOT_WSEL <= next_wsel;
    end
  end

  assign LOCK_POINTER = lock_ptr;

  // ****************************************
  // Valid store and hit gating
  // ****************************************
  assign vif.clear_all = flush;
  assign vif.set_en    = SLOT_WE;
  assign vif.set_slot  = SLOT_WSEL;
  assign vif.clr_en    = FLASH_INV;
  assign vif.clr_slot  = FLASH_INV_SLOT;
  assign vif.rd_en     = LOOKUP_REQ;
  assign vif.rd_slot   = LOOKUP_SLOT;

  logic lookup_q;
  logic next_lookup_q;
  logic next_hit;

  always_comb begin
    next_lookup_q = LOOKUP_REQ;
    next_hit      = lookup_q && vif.rd_valid && ctrl[bcc_pkg::RDEN_BIT] && !flush;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lookup_q <= 1'b0;
      HIT_USE  <= 1'b0;
    end else begin
      lookup_q <= next_lookup_q;
      HIT_USE  <= next_hit;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_wren_blocks_fill: assert property (@(posedge CLK) disable iff (!NRST)
    (!ctrl[bcc_pkg::WREN_BIT] && !PUSH_REQ) |=> !SLOT_WE)
    else $error("Slot written while cache writes disabled.");
  a_rden_blocks_hit: assert property (@(posedge CLK) disable iff (!NRST)
    !ctrl[bcc_pkg::RDEN_BIT] |=> !HIT_USE)
    else $error("Hit returned while cache reads disabled.");
  a_prefetch_follows: assert property (@(posedge CLK) disable iff (!NRST)
    ctrl_wr |=> PREFETCH_EN == $past(SFR_WDATA[bcc_pkg::PFEN_BIT]))
    else $error("Prefetch enable does not follow the written bit.");
  a_reti_gated: assert property (@(posedge CLK) disable iff (!NRST)
    (FILL_REQ && FILL_IS_RETI && !ctrl[bcc_pkg::RETI_BIT] && !PUSH_REQ) |=> !SLOT_WE)
    else $error("Return destination cached while disallowed.");
  a_isr_gated: assert property (@(posedge CLK) disable iff (!NRST)
    (FILL_REQ && FILL_IS_ISR && !ctrl[bcc_pkg::ISR_BIT] && !PUSH_REQ) |=> !SLOT_WE)
    else $error("Interrupt routine fetch cached while disallowed.");
  a_flush_clears: assert property (@(posedge CLK) disable iff (!NRST)
    (ctrl_wr && SFR_WDATA[bcc_pkg::FLSH_BIT]) |=> !ctrl[bcc_pkg::FLSH_BIT] ##1 !HIT_USE)
    else $error("Flush did not clear or bit reads back set.");
  a_movc_gated: assert property (@(posedge CLK) disable iff (!NRST)
    (FILL_REQ && FILL_IS_MOVC && !ctrl[bcc_pkg::MOVC_BIT] && !PUSH_REQ) |=> !SLOT_WE)
    else $error("Table read data cached while disallowed.");
  a_push_decrements: assert property (@(posedge CLK) disable iff (!NRST)
    (do_push && lock_ptr != bcc_pkg::SLOT_ZERO) |=>
      SLOT_WE && SLOT_WSEL == $past(lock_ptr) && lock_ptr == $past(lock_ptr) - 6'h01)
    else $error("Push did not write the pointed slot and decrement.");
  a_pop_increments: assert property (@(posedge CLK) disable iff (!NRST)
    (POP_REQ && !do_push && lock_ptr != bcc_pkg::LOCK_PTR_RST) |=>
      lock_ptr == $past(lock_ptr) + 6'h01)
    else $error("Pop did not increment the lock pointer.");
  a_fill_no_rden: assert property (@(posedge CLK) disable iff (!NRST)
    (do_fill && !ctrl[bcc_pkg::RDEN_BIT]) |=> SLOT_WE)
    else $error("Fill lost while cache reads disabled.");
  a_victim_unlocked: assert property (@(posedge CLK) disable iff (!NRST)
    do_fill |=> SLOT_WSEL <= $past(lock_ptr))
    else $error("Replacement chose a locked slot.");
endmodule

// *** test/bcc_core_model.sv ***
// Fetch path model of the processor core that drives cache requests.
`timescale 1ns/100ps
module bcc_core_model (
  input  wire logic       clk,
  output logic            lookup_req,
  output logic      [5:0] lookup_slot,
  output logic            fill_req,
  output logic      [2:0] fill_kind,
  output logic            push_req,
  output logic            pop_req,
  output logic            inv_req,
  output logic      [5:0] inv_slot
);
  initial begin
    {lookup_req, fill_req, push_req, pop_req, inv_req} = 5'h00;
    {lookup_slot, inv_slot, fill_kind} = 15'h0000;
  end
  // Op 0 lookup, 1 fill, 2 push, 3 pop, 4 flash invalidate; returns at the negedge that ends the one-cycle pulse.
  // Qualifiers are inverted after the pulse so that stale values can never help the design.
  task automatic pulse(input int op, input logic [5:0] slot, input logic [2:0] kind);
    @(negedge clk);
    {lookup_slot, inv_slot, fill_kind} = {slot, slot, kind};
    {lookup_req, fill_req, push_req, pop_req, inv_req} = 5'h10 >> op;
    @(negedge clk);
    {lookup_req, fill_req, push_req, pop_req, inv_req} = 5'h00;
    {lookup_slot, inv_slot, fill_kind} = ~{slot, slot, kind};
  endtask
endmodule

// *** test/tb.sv ***
// Self-checking bench for the branch cache control block.
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
  logic       clk = 1'b0, nrst = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, d;
  logic [5:0] s;
  logic [2:0] kind;
  logic       lreq, freq, preq, qreq, ireq;
  logic [5:0] lslot, islot;
  wire  [7:0] rdata;
  wire  [5:0] wsel, lptr;
  wire        hit, we, pfen, blkw;
  int         miscompares = 0, num_checks = 0;
  logic [11:0] rows [11] = '{{8'he6, 4'h1}, {8'h66, 4'h0}, {8'he6, 4'h8}, {8'hee, 4'h9},
    {8'he2, 4'h4}, {8'he6, 4'h5}, {8'he4, 4'h2}, {8'he6, 4'h3}, {8'ha6, 4'h1},
    {8'hc6, 4'h1}, {8'he7, 4'h1}};
  bcc_top u_bcc_top (.CLK(clk), .NRST(nrst), .SFR_ADDR(addr), .SFR_WR(wr_s), .SFR_RD(rd_s),
    .SFR_WDATA(wdata), .SFR_RDATA(rdata), .LOOKUP_REQ(lreq), .LOOKUP_SLOT(lslot),
    .HIT_USE(hit), .FILL_REQ(freq), .FILL_IS_RETI(kind[2]), .FILL_IS_ISR(kind[1]),
    .FILL_IS_MOVC(kind[0]), .PUSH_REQ(preq), .POP_REQ(qreq), .FLASH_INV(ireq),
    .FLASH_INV_SLOT(islot), .SLOT_WE(we), .SLOT_WSEL(wsel), .LOCK_POINTER(lptr),
    .PREFETCH_EN(pfen), .FLASH_BLOCK_WRITE(blkw));
  bcc_core_model u_bcc_core_model (.clk(clk), .lookup_req(lreq), .lookup_slot(lslot),
    .fill_req(freq), .fill_kind(kind), .push_req(preq), .pop_req(qreq), .inv_req(ireq),
    .inv_slot(islot));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic wr(input logic [7:0] v);
    @(negedge clk);
    {addr, wdata, wr_s} = {bcc_pkg::CTRL_ADDR, v, 1'b1};
    @(negedge clk);
    {wr_s, wdata} = {1'b0, ~v};
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    {addr, rd_s} = {a, 1'b1};
    @(negedge clk);
    rd_s = 1'b0;
    d = rdata;
  endtask
  // Lookup result arrives two cycles after the request, so wait one more cycle.
  task automatic look(input logic [5:0] sl, input logic e);
    u_bcc_core_model.pulse(0, sl, 3'h0);
    @(negedge clk);
    `CHK("hit", e, hit);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    stop_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    `CHK("lptr", 6'h3f, lptr);
    `CHK("pfen", 1'b1, pfen);
    `CHK("we", 1'b0, we);
    rd(bcc_pkg::CTRL_ADDR);
    `CHK("ctrl", bcc_pkg::CTRL_RST, d);
    rd(8'ha2);
    `CHK("other", 8'h00, d);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i][11:4]);
      rd(bcc_pkg::CTRL_ADDR);
      `CHK("ctrl", rows[i][11:4] & 8'hef, d);
      `CHK("pfen", rows[i][9], pfen);
      `CHK("blkw", rows[i][4], blkw);
      u_bcc_core_model.pulse(1, 6'h00, rows[i][3:1]);
      `CHK("fill", rows[i][0], we);
    end
    $display("row test done");
    wr(8'he6);
    u_bcc_core_model.pulse(1, 6'h00, 3'h0);
    s = wsel;
    look(s, 1'b1);
    wr(8'ha6);
    look(s, 1'b0);
    wr(8'h66);
    u_bcc_core_model.pulse(4, s, 3'h0);
    wr(8'he6);
    look(s, 1'b0);
    u_bcc_core_model.pulse(1, 6'h00, 3'h0);
    s = wsel;
    wr(8'hf6);
    rd(bcc_pkg::CTRL_ADDR);
    `CHK("flushrd", 8'he6, d);
    look(s, 1'b0);
    $display("hit test done");
    wr(8'h66);
    u_bcc_core_model.pulse(2, 6'h00, 3'h0);
    `CHK("push_we", 1'b1, we);
    `CHK("push_sel", 6'h3f, wsel);
    u_bcc_core_model.pulse(2, 6'h00, 3'h0);
    `CHK("lptr", 6'h3d, lptr);
    u_bcc_core_model.pulse(3, 6'h00, 3'h0);
    `CHK("lptr", 6'h3e, lptr);
    `CHK("pop_we", 1'b0, we);
    wr(8'he6);
    look(6'h3e, 1'b1);
    u_bcc_core_model.pulse(2, 6'h00, 3'h0);
    for (int i = 0; i < 70; i++) begin
      u_bcc_core_model.pulse(1, 6'h00, 3'h0);
      `CHK("fill_we", 1'b1, we);
      `CHK("victim", 1'b1, wsel <= 6'h3d);
    end
    look(6'h3f, 1'b1);
    $display("lock test done");
    @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    `CHK("lptr", 6'h3f, lptr);
    nrst = 1'b1;
    u_bcc_core_model.pulse(3, 6'h00, 3'h0);
    `CHK("lptr_top", 6'h3f, lptr);
    $display("second reset test done");
    stop_test();
  end
endmodule
